/* File: hw/gated_timer_counter.sv */
// Sixteen-bit gated timer/counter with source select and prescaler
`timescale 1ns/1ns
module gated_timer_counter
  import gtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic module_on,
  input wire logic gate_enable,
  input wire logic gate_polarity,
  input wire logic gate_pin,
  input wire logic [1:0] count_source_select,
  input wire logic [1:0] prescale_select,
  input wire logic sync_disable,
  input wire logic external_count_pin,
  input wire logic low_freq_internal_osc,
  input wire logic sleep,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wr_data,
  input wire logic overflow_clear,
  output logic [7:0] count_high_byte,
  output logic [7:0] count_low_byte,
  output logic overflow_flag,
  output logic wake_request
);
  logic rst_meta_reg;          // Reset release stage one
  logic rst_n;                 // Reset release stage two, used everywhere
  logic [1:0] div_reg;         // Instruction clock divider
  logic instr_tick;            // One cycle per instruction cycle
  logic lfosc_prev_reg;        // Previous oscillator level
  logic lfosc_tick;            // Rising edge of the oscillator
  logic [2:0] pre_reg;         // Hidden prescale counter
  logic [CNT_W-1:0] count_reg; // Running count
  logic flag_reg;              // Sticky overflow flag
  logic wake_reg;              // Wake request towards the core
  logic src_tick;              // Selected source event
  logic gate_ok;               // Gate allows counting
  logic run;                   // Counter switched on and gated in
  logic awake_ok;              // Source keeps running in this power state
  logic pre_done;              // Prescaler reaches its terminal count
  logic inc;                   // Count advances this cycle
  logic any_write;             // Either byte is being written
  logic rollover;              // Advance from all-ones to zero
  edge_if eif();

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Instruction clock divider; frozen during sleep like the core clocks
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= DIV_RST;
    else if (!sleep)
      div_reg <= 2'(div_reg + 2'h1);
  end

  assign instr_tick = (div_reg == DIV_LAST);

  // Oscillator edge detector; the pin is taken as synchronous already
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lfosc_prev_reg <= 1'b0;
    else
      lfosc_prev_reg <= low_freq_internal_osc;
  end

  assign lfosc_tick = low_freq_internal_osc && !lfosc_prev_reg;

  // Count-pin path: disarmed on write or while off
  assign any_write = wr_high || wr_low;
  assign eif.pin_level = external_count_pin;
  assign eif.sync_disable = sync_disable;
  assign eif.disarm = any_write || !module_on;

  count_edge_unit u_edge (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .eif (eif)
  );

  // Source selection
  always_comb
  begin
    case (count_source_select)
      SRC_LFOSC: src_tick = lfosc_tick;
      SRC_PIN: src_tick = eif.rise_pulse;
      SRC_SYS: src_tick = 1'b1;
      default: src_tick = instr_tick;
    endcase
  end

  // Enable and gate; gate level compared with polarity
  assign gate_ok = !gate_enable || (gate_pin == gate_polarity);
  assign run = module_on && gate_ok;
  // Only the unsynchronised pin path survives sleep
  assign awake_ok = !sleep || (count_source_select == SRC_PIN && sync_disable);
  assign pre_done = (pre_reg == prescale_last(prescale_select));
  assign inc = run && awake_ok && src_tick && pre_done && !any_write;
  assign rollover = inc && (count_reg == COUNT_MAX);

  // Prescale counter: cleared by any byte write, never visible
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_reg <= PRESCALE_RST;
    else if (any_write)
      pre_reg <= PRESCALE_RST;
    else if (run && awake_ok && src_tick)
    begin
      if (pre_done)
        pre_reg <= PRESCALE_RST;
      else
        pre_reg <= 3'(pre_reg + 3'h1);
    end
  end

  // Running count; a write wins over an increment in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= COUNT_RST;
    else
    begin
      if (wr_high)
        count_reg[CNT_W-1:BYTE_W] <= wr_data;
      if (wr_low)
        count_reg[BYTE_W-1:0] <= wr_data;
      if (inc)
        count_reg <= CNT_W'(count_reg + 16'h0001);
    end
  end

  // Overflow flag: set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= 1'b0;
    else if (rollover)
      flag_reg <= 1'b1;
    else if (overflow_clear)
      flag_reg <= 1'b0;
  end

  // Wake request: a rollover seen while asleep
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wake_reg <= 1'b0;
    else
      wake_reg <= rollover && sleep;
  end

  assign count_high_byte = count_reg[CNT_W-1:BYTE_W];
  assign count_low_byte = count_reg[BYTE_W-1:0];
  assign overflow_flag = flag_reg;
  assign wake_request = wake_reg;

  a_off_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!module_on && !any_write) |=> $stable(count_reg))
    else $error("Count changed while module off");
  a_gate_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (gate_enable && gate_pin != gate_polarity && !any_write) |=> $stable(count_reg))
    else $error("Count changed while gate closed");
  a_sys_four: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (module_on && !gate_enable && !sleep && count_source_select == SRC_SYS
     && prescale_select == 2'h0 && !any_write && count_reg != COUNT_MAX) [*4]
    |=> count_reg == $past(count_reg, 4) + 16'h0004)
    else $error("System clock source did not add four per instruction");
  a_instr_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (module_on && !gate_enable && !sleep && count_source_select == SRC_INSTR
     && prescale_select == 2'h0 && !any_write && count_reg < 16'hFFF0) [*4]
    |=> count_reg == $past(count_reg, 4) + 16'h0001)
    else $error("Instruction source did not add one per instruction");
  a_write_loads: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_low |=> count_low_byte == $past(wr_data))
    else $error("Low byte write not loaded");
  a_write_prescale: assert property (@(posedge clk_sys) disable iff (!rst_n)
    any_write |=> pre_reg == PRESCALE_RST)
    else $error("Prescaler not cleared by write");
  a_prescale_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inc |-> pre_reg == prescale_last(prescale_select))
    else $error("Advance before prescale terminal count");
  a_roll_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (count_reg == COUNT_MAX && inc) |=> (flag_reg && count_reg == COUNT_RST))
    else $error("Rollover did not set flag");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (flag_reg && !overflow_clear) |=> flag_reg)
    else $error("Flag dropped without software clear");
  a_sleep_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sleep && count_source_select != SRC_PIN && !any_write) |=> $stable(count_reg))
    else $error("Internal source counted during sleep");
endmodule

/* File: hw/gtc_pkg.sv */
// Constants and helpers shared by the gated timer/counter design
package gtc_pkg;
  localparam int unsigned CNT_W = 16;            // Width of the running count
  localparam int unsigned BYTE_W = 8;            // Width of one count byte
  localparam int unsigned CLK_HZ = 20000000;     // System clock rate
  localparam int unsigned INSTR_DIV = 4;         // System clocks per instruction cycle
  localparam int unsigned INSTR_NS = 1000000000 / CLK_HZ * INSTR_DIV; // Instruction cycle in ns
  localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1); // Last phase of the divider
  localparam logic [1:0] SRC_LFOSC = 2'h3;       // Low-frequency internal oscillator
  localparam logic [1:0] SRC_PIN = 2'h2;         // External count pin
  localparam logic [1:0] SRC_SYS = 2'h1;         // Full-rate system clock
  localparam logic [1:0] SRC_INSTR = 2'h0;       // Instruction clock
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000; // Count after reset
  localparam logic [CNT_W-1:0] COUNT_MAX = 16'hFFFF; // Value that rolls over
  localparam logic [2:0] PRESCALE_RST = 3'h0;    // Prescale counter after reset
  localparam logic [1:0] DIV_RST = 2'h0;         // Instruction divider after reset

  // Terminal prescale count for a 1, 2, 4 or 8 division
  function automatic logic [2:0] prescale_last(input logic [1:0] sel);
    prescale_last = 3'((4'h1 << sel) - 4'h1);
  endfunction
endpackage

/* File: hw/edge_if.sv */
// Signals between the counter core and its count-pin edge unit
`timescale 1ns/1ns
interface edge_if;
  logic pin_level;    // Count pin as sampled
  logic sync_disable; // High selects the unsynchronised path
  logic disarm;       // High forces a new falling edge before counting
  logic rise_pulse;   // One-cycle accepted rising edge
  modport unit (input pin_level, input sync_disable, input disarm, output rise_pulse);
  modport core (output pin_level, output sync_disable, output disarm, input rise_pulse);
endinterface

/* File: hw/count_edge_unit.sv */
// Count-pin synchroniser, rising-edge detector and falling-edge arming
`timescale 1ns/1ns
module count_edge_unit
  import gtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  edge_if.unit eif
);
  logic sync1_reg;   // First synchroniser stage, read only by the second
  logic sync2_reg;   // Second synchroniser stage
  logic prev_reg;    // Level seen on the previous cycle
  logic armed_reg;   // A falling edge has been seen since disarm
  logic rise_reg;    // Registered accepted edge
  logic level;       // Level chosen by the sync mode

  // Two-stage synchroniser on the count pin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= eif.pin_level;
      sync2_reg <= sync1_reg;
    end
  end

  // Bypass skips the two stages, so a mode change can gain or lose an edge
  assign level = eif.sync_disable ? eif.pin_level : sync2_reg;

  // Previous level for edge detection
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= 1'b0;
    else
      prev_reg <= level;
  end

  // Arming: disarm wins, then a falling edge arms
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      armed_reg <= 1'b0;
    else if (eif.disarm)
      armed_reg <= 1'b0;
    else if (prev_reg && !level)
      armed_reg <= 1'b1;
  end

  // Accepted rising edge, only once armed
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rise_reg <= 1'b0;
    else
      rise_reg <= level && !prev_reg && armed_reg && !eif.disarm;
  end

  assign eif.rise_pulse = rise_reg;

  a_rise_needs_arm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rise_reg |-> $past(armed_reg))
    else $error("Rising edge accepted without prior falling edge");
endmodule

/* File: test/pulse_source.sv */
// Model of the external pulse source that drives the count pin
`timescale 1ns/1ns
module pulse_source (
  input wire logic clk_sys,
  output logic pin
);
  // Pin idles low between bursts, so no stray edge reaches the counter
  initial
  begin
    pin = 1'b0;
  end

  // Emit n rising edges; half sets both high and low time in clocks
  // A half of one is the fastest legal source, larger halves model a slow one
  task automatic emit(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(negedge clk_sys);
      pin = 1'b1;
      repeat (half) @(negedge clk_sys);
      pin = 1'b0;
    end
  endtask
endmodule

/* File: test/sixteen_bit_gated_timer_counter_tb.sv */
// Self-checking bench for the gated timer/counter
`timescale 1ns/1ns
module sixteen_bit_gated_timer_counter_tb;
  import gtc_pkg::*;
  logic clk_sys, rstn, module_on, gate_enable, gate_polarity, gate_pin, sync_disable;
  logic low_freq_internal_osc, sleep, wr_high, wr_low, overflow_clear;
  logic overflow_flag, wake_request, external_count_pin;
  logic [1:0] count_source_select, prescale_select;
  logic [7:0] wr_data, count_high_byte, count_low_byte;
  int err_total, tests_run, wake_cnt, n, k; // Counters and scratch
  logic [15:0] base, exp_v; // Start value and expected count
  wire [15:0] count = {count_high_byte, count_low_byte}; // Full count

  gated_timer_counter gated_timer_counter_inst (.clk_sys(clk_sys), .rstn(rstn),
    .module_on(module_on), .gate_enable(gate_enable), .gate_polarity(gate_polarity),
    .gate_pin(gate_pin), .count_source_select(count_source_select),
    .prescale_select(prescale_select), .sync_disable(sync_disable),
    .external_count_pin(external_count_pin), .low_freq_internal_osc(low_freq_internal_osc),
    .sleep(sleep), .wr_high(wr_high), .wr_low(wr_low), .wr_data(wr_data),
    .overflow_clear(overflow_clear), .count_high_byte(count_high_byte),
    .count_low_byte(count_low_byte), .overflow_flag(overflow_flag),
    .wake_request(wake_request));
  pulse_source pulse_source_inst (.clk_sys(clk_sys), .pin(external_count_pin));

  // Free-running system clock, 50 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Wake pulses last one cycle; counted at the falling edge, away from the launching edge
  always @(negedge clk_sys)
    if (wake_request === 1'b1)
      wake_cnt++;

  // Hang guard: a stuck run is cut short and reported as failed
  initial
  begin
    #2000000;
    err_total++;
    $display("timeout reached");
    results();
  end

  // Compare and report one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Load both bytes back to back; the counter must be off meanwhile
  task automatic wr16(input logic [15:0] v);
    @(negedge clk_sys);
    wr_high = 1'b1;
    wr_data = v[15:8];
    @(negedge clk_sys);
    wr_high = 1'b0;
    wr_low = 1'b1;
    wr_data = v[7:0];
    @(negedge clk_sys);
    wr_low = 1'b0;
  endtask

  // Hold the counter on for cyc edges, then let late increments land
  task automatic run(input int cyc);
    @(negedge clk_sys);
    module_on = 1'b1;
    repeat (cyc) @(negedge clk_sys);
    module_on = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // Increments expected from an internal source after cyc clocks
  function automatic logic [15:0] incs(input logic [1:0] src, input logic [1:0] ps,
    input int cyc);
    int ev;
    ev = (src == SRC_SYS) ? cyc : cyc / INSTR_DIV;
    return 16'(ev >> ps);
  endfunction

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    {module_on, gate_enable, gate_polarity, gate_pin, sync_disable} = 5'h00;
    {low_freq_internal_osc, sleep, wr_high, wr_low, overflow_clear} = 5'h00;
    count_source_select = SRC_SYS;
    prescale_select = 2'h0;
    wr_data = 8'h00;
    {err_total, tests_run, wake_cnt} = '0;
    rstn = 1'b0;
    void'($urandom(32'h81E087CB));
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(count, COUNT_RST);
    check(16'(overflow_flag), 16'h0000);
    done("reset");
    // System and instruction clock sources over every prescale; gate state fixed for the first four passes, then drawn at random
    for (int t = 0; t < 8; t++)
    begin
      count_source_select = t[0] ? SRC_SYS : SRC_INSTR;
      prescale_select = 2'(t >> 1);
      // First two passes ungated, then one closed and one open gate, then random
      gate_enable = (t < 2) ? 1'b0 : ((t < 4) ? 1'b1 : 1'($urandom));
      gate_polarity = 1'($urandom);
      gate_pin = (t == 2) ? ~gate_polarity : ((t == 3) ? gate_polarity : 1'($urandom));
      base = 16'($urandom_range(0, 16'hE000));
      n = 4 * $urandom_range(3, 60);
      wr16(base);
      run(n);
      exp_v = (gate_enable && gate_pin !== gate_polarity) ? base : base +
        incs(count_source_select, prescale_select, n);
      check(count, exp_v);
      repeat (4) @(negedge clk_sys);
      check(count, exp_v);
    end
    done("internal");
    // Oscillator source counts its own rising edges
    {gate_enable, prescale_select, count_source_select} = {1'b0, 2'h0, SRC_LFOSC};
    wr16(16'h1234);
    @(negedge clk_sys);
    module_on = 1'b1;
    k = $urandom_range(2, 9);
    repeat (k)
    begin
      repeat (2) @(negedge clk_sys);
      low_freq_internal_osc = 1'b1;
      repeat (2) @(negedge clk_sys);
      low_freq_internal_osc = 1'b0;
    end
    run(4);
    check(count, 16'h1234 + 16'(k));
    done("oscillator");
    // Pin source, both modes: first rise after a write is ignored
    count_source_select = SRC_PIN;
    for (int s = 0; s < 2; s++)
    begin
      sync_disable = 1'(s);
      base = 16'($urandom_range(0, 16'hE000));
      wr16(base);
      @(negedge clk_sys);
      module_on = 1'b1;
      k = $urandom_range(2, 12);
      pulse_source_inst.emit(k, $urandom_range(1, 5));
      run(8);
      check(count, base + 16'(k - 1));
    end
    done("pin");
    // Sleep blocks the system clock source
    count_source_select = SRC_SYS;
    wr16(16'h0005);
    sleep = 1'b1;
    run(20);
    sleep = 1'b0;
    check(count, 16'h0005);
    // Async pin counting rolls over in sleep and asks for a wake-up
    {count_source_select, sync_disable} = {SRC_PIN, 1'b1};
    wr16(16'hFFFE);
    sleep = 1'b1;
    @(negedge clk_sys);
    module_on = 1'b1;
    pulse_source_inst.emit(3, 2);
    run(8);
    sleep = 1'b0;
    check(count, COUNT_RST);
    check(16'(overflow_flag), 16'h0001);
    check(16'(wake_cnt), 16'h0001);
    wr16(16'h0100);
    check(16'(overflow_flag), 16'h0001);
    @(negedge clk_sys);
    overflow_clear = 1'b1;
    @(negedge clk_sys);
    overflow_clear = 1'b0;
    @(negedge clk_sys);
    check(16'(overflow_flag), 16'h0000);
    // A clear in the rollover cycle loses to the set
    count_source_select = SRC_SYS;
    wr16(16'hFFFF);
    @(negedge clk_sys);
    {module_on, overflow_clear} = 2'h3;
    @(negedge clk_sys);
    {module_on, overflow_clear} = 2'h0;
    @(negedge clk_sys);
    check(16'(overflow_flag), 16'h0001);
    check(count, COUNT_RST);
    done("overflow");
    // Sync mode changed in mid-run both ways: one count either way is allowed
    {count_source_select, sync_disable} = {SRC_PIN, 1'b0};
    wr16(16'h0200);
    @(negedge clk_sys);
    module_on = 1'b1;
    pulse_source_inst.emit(4, 3);
    sync_disable = 1'b1;
    pulse_source_inst.emit(4, 3);
    repeat (8) @(negedge clk_sys);
    check(16'(count >= 16'h0206 && count <= 16'h0208), 16'h0001);
    n = int'(count);
    sync_disable = 1'b0;
    pulse_source_inst.emit(4, 3);
    run(8);
    check(16'(int'(count) >= n + 3 && int'(count) <= n + 5), 16'h0001);
    done("switch");
    results();
  end
endmodule
